// File: hdl/sio_dram_pkg.sv
package sio_dram_pkg;
  // pin widths
  localparam int ADDR_W = 22;
  localparam int BANK_W = 3;
  localparam int DATA_W = 18;
  localparam int MODE_W = 18;
  // modelled storage: sixteen locations per bank, one row counter per bank
  localparam int LOC_W = 4;
  localparam int IDX_W = BANK_W + LOC_W;
  localparam int BANKS = 8;
  localparam int ROW_W = 13;
  // write path: up to four beat pairs per burst, four burst slots across the crossing
  localparam int PAIRS = 4;
  localparam int SLOTS = 4;
  localparam int PTR_W = 2;
  localparam int QPTR_W = 3;
  // read delay line and its base latency
  localparam int DLY_MAX = 12;
  localparam int READ_DELAY_BASE = 4;
  // mode word field positions and reset value
  localparam int CFG_LSB = 0;
  localparam int CFG_W = 3;
  localparam int BURST_LSB = 3;
  localparam logic [MODE_W-1:0] MODE_RESET = 18'h00000;
  localparam logic [1:0] BURST_CODE_4 = 2'h1;
  localparam logic [1:0] BURST_CODE_8 = 2'h2;

  typedef enum {CMD_IDLE, CMD_MODE, CMD_READ, CMD_WRITE, CMD_REF} cmd_kind_t;
  typedef enum {RD_IDLE, RD_BURST} rd_state_t;
  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [LOC_W-1:0] loc;
  } acc_t;
  typedef struct packed {
    logic mask;
    logic [DATA_W-1:0] data;
  } beat_t;

  // words per burst; both other codes, 0 and 3, fall back to two
  function automatic logic [3:0] burst_words(input logic [1:0] code);
    case (code)
      BURST_CODE_4: burst_words = 4'h4;
      BURST_CODE_8: burst_words = 4'h8;
      default: burst_words = 4'h2;
    endcase
  endfunction

  // index of the last beat pair of a burst
  function automatic logic [1:0] last_pair(input logic [1:0] code);
    case (code)
      BURST_CODE_4: last_pair = 2'h1;
      BURST_CODE_8: last_pair = 2'h3;
      default: last_pair = 2'h0;
    endcase
  endfunction

  // storage index of beat off within a burst, wrapping inside the bank
  function automatic logic [IDX_W-1:0] word_idx(input acc_t a, input int off);
    word_idx = {a.bank, LOC_W'(a.loc + LOC_W'(off))};
  endfunction
endpackage

// File: hdl/sio_dram_wr_capture.sv
`timescale 1ns/1ps
`default_nettype none
module sio_dram_wr_capture (
  // link clock and reset
  input wire logic wdclk,
  input wire logic rstn,
  // write data pins, one beat per edge
  input wire logic [sio_dram_pkg::DATA_W-1:0] wdata,
  input wire logic wmask,
  // burst length code from the command side, changes only while idle
  input wire logic [1:0] burst_code,
  // burst slots, stable once the pointer has passed them
  output var sio_dram_pkg::beat_t even_beats [sio_dram_pkg::SLOTS][sio_dram_pkg::PAIRS],
  output var sio_dram_pkg::beat_t odd_beats [sio_dram_pkg::SLOTS][sio_dram_pkg::PAIRS],
  output logic [sio_dram_pkg::PTR_W-1:0] wptr_gray
);
  logic [1:0] burst_meta_r;
  logic [1:0] burst_sync_r;
  logic [1:0] epair_r;
  logic [1:0] opair_r;
  logic [sio_dram_pkg::PTR_W-1:0] wptr_r;
  logic [1:0] last;

  // burst length crosses as a quasi-static level
  always_ff @(posedge wdclk or negedge rstn) begin
    if (!rstn) begin
      burst_meta_r <= 2'h0;
      burst_sync_r <= 2'h0;
    end else begin
      burst_meta_r <= burst_code;
      burst_sync_r <= burst_meta_r;
    end
  end

  assign last = sio_dram_pkg::last_pair(burst_sync_r);

  // rising edge counts the even beats of the burst
  always_ff @(posedge wdclk or negedge rstn) begin
    if (!rstn) begin
      epair_r <= 2'h0;
    end else begin
      epair_r <= (epair_r == last) ? 2'h0 : epair_r + 2'h1;
    end
  end

  // even beat and its mask are taken together on the rising edge
  always_ff @(posedge wdclk) begin
    even_beats[wptr_r][epair_r] <= '{mask: wmask, data: wdata};
  end

  // odd beat on the falling edge
  always_ff @(negedge wdclk) begin
    odd_beats[wptr_r][opair_r] <= '{mask: wmask, data: wdata};
  end

  // the falling edge of the last pair closes the slot; the pointer moves in gray code
  always_ff @(negedge wdclk or negedge rstn) begin
    if (!rstn) begin
      opair_r <= 2'h0;
      wptr_r <= '0;
      wptr_gray <= '0;
    end else if (opair_r == last) begin
      opair_r <= 2'h0;
      wptr_r <= wptr_r + 1'b1;
      wptr_gray <= (wptr_r + 1'b1) ^ ((wptr_r + 1'b1) >> 1);
    end else begin
      opair_r <= opair_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/sio_dram_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - commands registered on input clock rising edge
// - idle command leaves running bursts alone
// - mode load captures address bits 0..17
// - read bursts from selected bank and location
// - write bursts to selected bank and location
// - high mask keeps stored word unchanged
// - refresh uses bank plus internal row counter
// - clock zero low lanes, one high
// - deselected chip accepts no command
// - bursts of two, four or eight words
// - write data on both data clock edges
module sio_dram_cmd_if (
  // command clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // command and address pins
  input wire logic CHIP_SELECT_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic REFRESH_ENABLE_N,
  input wire logic [sio_dram_pkg::BANK_W-1:0] BANK_SELECT,
  input wire logic [sio_dram_pkg::ADDR_W-1:0] LOCATION_ADDRESS,
  // write data link
  input wire logic WRITE_DATA_CLOCK,
  input wire logic [sio_dram_pkg::DATA_W-1:0] WRITE_DATA,
  input wire logic WRITE_MASK,
  // read data
  output logic [sio_dram_pkg::DATA_W-1:0] READ_DATA,
  output logic READ_VALID_FLAG,
  output logic [1:0] READ_DATA_CLOCK,
  // state
  output logic [sio_dram_pkg::MODE_W-1:0] MODE_WORD,
  output logic REFRESH_STROBE,
  output logic [sio_dram_pkg::ROW_W-1:0] REFRESH_ROW
);
  sio_dram_pkg::cmd_kind_t cmd;
  sio_dram_pkg::acc_t cmd_acc, head, tap_a, rd_acc_r;
  logic [3:0] words_per_burst, delay_tap, rd_cnt_r;
  logic [sio_dram_pkg::DATA_W-1:0] mem [2**sio_dram_pkg::IDX_W];
  logic [sio_dram_pkg::ROW_W-1:0] row_of [sio_dram_pkg::BANKS];
  logic [sio_dram_pkg::ROW_W-1:0] ref_row_sel;
  sio_dram_pkg::acc_t wq_r [2**(sio_dram_pkg::QPTR_W-1)];
  logic [sio_dram_pkg::QPTR_W-1:0] wq_wr_r, wq_rd_r;
  logic wq_empty, burst_ready, commit_now, beat0_mask, tap_v;
  sio_dram_pkg::beat_t even_beats [sio_dram_pkg::SLOTS][sio_dram_pkg::PAIRS];
  sio_dram_pkg::beat_t odd_beats [sio_dram_pkg::SLOTS][sio_dram_pkg::PAIRS];
  logic [sio_dram_pkg::PTR_W-1:0] wptr_gray, gray_meta_r, gray_sync_r, wptr_bin, rptr_r;
  logic [sio_dram_pkg::IDX_W-1:0] head_idx;
  logic [sio_dram_pkg::DATA_W-1:0] head_word, beat0_data;
  logic [sio_dram_pkg::DLY_MAX-1:0] dly_v_r;
  sio_dram_pkg::acc_t dly_a_r [sio_dram_pkg::DLY_MAX];
  sio_dram_pkg::rd_state_t rd_state_r;

  // pins are already aligned to the rising edge, so no synchroniser here
  always_comb begin
    cmd = sio_dram_pkg::CMD_IDLE;
    if (!CHIP_SELECT_N) begin
      case ({WRITE_ENABLE_N, REFRESH_ENABLE_N})
        2'b00: cmd = sio_dram_pkg::CMD_MODE;
        2'b11: cmd = sio_dram_pkg::CMD_READ;
        2'b01: cmd = sio_dram_pkg::CMD_WRITE;
        2'b10: cmd = sio_dram_pkg::CMD_REF;
        default: cmd = sio_dram_pkg::CMD_IDLE;
      endcase
    end
  end
  assign cmd_acc = '{bank: BANK_SELECT, loc: LOCATION_ADDRESS[sio_dram_pkg::LOC_W-1:0]};
  assign words_per_burst = sio_dram_pkg::burst_words(MODE_WORD[sio_dram_pkg::BURST_LSB +: 2]);

  // mode word; reloading it mid-burst is the controller's fault, not guarded here
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MODE_WORD <= sio_dram_pkg::MODE_RESET;
    end else if (cmd == sio_dram_pkg::CMD_MODE) begin
      MODE_WORD <= LOCATION_ADDRESS[sio_dram_pkg::MODE_W-1:0];
    end
  end

  // one row counter per bank; address pins are ignored on refresh
  for (genvar b = 0; b < sio_dram_pkg::BANKS; b++) begin : g_bank
    logic [sio_dram_pkg::ROW_W-1:0] cnt_r;
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
        cnt_r <= '0;
      end else if (cmd == sio_dram_pkg::CMD_REF && BANK_SELECT == sio_dram_pkg::BANK_W'(b)) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
    assign row_of[b] = cnt_r;
  end

  assign ref_row_sel = row_of[BANK_SELECT];

  // report which row each refresh used
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REFRESH_STROBE <= 1'b0;
      REFRESH_ROW <= '0;
    end else begin
      REFRESH_STROBE <= (cmd == sio_dram_pkg::CMD_REF);
      if (cmd == sio_dram_pkg::CMD_REF) begin
        REFRESH_ROW <= ref_row_sel;
      end
    end
  end

  // write commands wait here until their data burst has crossed over
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wq_wr_r <= '0;
      wq_rd_r <= '0;
    end else begin
      wq_wr_r <= wq_wr_r + sio_dram_pkg::QPTR_W'(cmd == sio_dram_pkg::CMD_WRITE);
      wq_rd_r <= wq_rd_r + sio_dram_pkg::QPTR_W'(commit_now);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (cmd == sio_dram_pkg::CMD_WRITE) begin
      wq_r[wq_wr_r[sio_dram_pkg::QPTR_W-2:0]] <= cmd_acc;
    end
  end

  assign wq_empty = (wq_wr_r == wq_rd_r);
  assign head = wq_r[wq_rd_r[sio_dram_pkg::QPTR_W-2:0]];

  // write beats are captured on the data clock's own edges
  sio_dram_wr_capture u_wr_capture (
    .wdclk(WRITE_DATA_CLOCK),
    .rstn(RSTN),
    .wdata(WRITE_DATA),
    .wmask(WRITE_MASK),
    .burst_code(MODE_WORD[sio_dram_pkg::BURST_LSB +: 2]),
    .even_beats(even_beats),
    .odd_beats(odd_beats),
    .wptr_gray(wptr_gray)
  );

  // gray pointer through two flops; slot contents are stable once it arrives
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gray_meta_r <= '0;
      gray_sync_r <= '0;
    end else begin
      gray_meta_r <= wptr_gray;
      gray_sync_r <= gray_meta_r;
    end
  end

  assign wptr_bin = {gray_sync_r[1], gray_sync_r[1] ^ gray_sync_r[0]};
  assign burst_ready = (rptr_r != wptr_bin);
  assign commit_now = burst_ready && !wq_empty;
  assign head_idx = sio_dram_pkg::word_idx(head, 0);
  assign head_word = mem[head_idx];
  assign beat0_mask = even_beats[rptr_r][0].mask;
  assign beat0_data = even_beats[rptr_r][0].data;

  // a burst with no write command behind it is dropped so the pointers stay aligned
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rptr_r <= '0;
    end else if (burst_ready) begin
      rptr_r <= rptr_r + 1'b1;
    end
  end

  // storage: whole burst written in one cycle, beats whose mask is high are skipped
  always_ff @(posedge SYS_CLK) begin
    if (commit_now) begin
      for (int p = 0; p < sio_dram_pkg::PAIRS; p++) begin
        if (2 * p < int'(words_per_burst) && !even_beats[rptr_r][p].mask) begin
          mem[sio_dram_pkg::word_idx(head, 2 * p)] <= even_beats[rptr_r][p].data;
        end
        if (2 * p < int'(words_per_burst) && !odd_beats[rptr_r][p].mask) begin
          mem[sio_dram_pkg::word_idx(head, 2 * p + 1)] <= odd_beats[rptr_r][p].data;
        end
      end
    end
  end

  // read latency line; tap follows the configuration field
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dly_v_r <= '0;
    end else begin
      dly_v_r <= {dly_v_r[sio_dram_pkg::DLY_MAX-2:0], cmd == sio_dram_pkg::CMD_READ};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    dly_a_r[0] <= cmd_acc;
    for (int i = 1; i < sio_dram_pkg::DLY_MAX; i++) begin
      dly_a_r[i] <= dly_a_r[i-1];
    end
  end
  assign delay_tap = 4'(sio_dram_pkg::READ_DELAY_BASE - 1)
    + {1'b0, MODE_WORD[sio_dram_pkg::CFG_LSB +: sio_dram_pkg::CFG_W]};
  assign tap_v = dly_v_r[delay_tap];
  assign tap_a = dly_a_r[delay_tap];

  // read burst engine; a due read restarts it, idle commands never touch it
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_state_r <= sio_dram_pkg::RD_IDLE;
      rd_cnt_r <= 4'h0;
      rd_acc_r <= '0;
      READ_DATA <= '0;
      READ_VALID_FLAG <= 1'b0;
    end else if (tap_v) begin
      rd_acc_r <= tap_a;
      rd_cnt_r <= 4'h1;
      READ_DATA <= mem[sio_dram_pkg::word_idx(tap_a, 0)];
      READ_VALID_FLAG <= 1'b1;
      rd_state_r <= sio_dram_pkg::RD_BURST;
    end else begin
      case (rd_state_r)
        sio_dram_pkg::RD_BURST: begin
          if (rd_cnt_r < words_per_burst) begin
            READ_DATA <= mem[sio_dram_pkg::word_idx(rd_acc_r, int'(rd_cnt_r))];
            READ_VALID_FLAG <= 1'b1;
            rd_cnt_r <= rd_cnt_r + 4'h1;
          end else begin
            READ_VALID_FLAG <= 1'b0;
            rd_state_r <= sio_dram_pkg::RD_IDLE;
          end
        end
        default: begin
          READ_VALID_FLAG <= 1'b0;
        end
      endcase
    end
  end

  // free-running output clocks, one per lane group, both in phase with the word
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      READ_DATA_CLOCK <= 2'h0;
    end else begin
      READ_DATA_CLOCK <= ~READ_DATA_CLOCK;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  chk_mode_capture: assert property (
    cmd == sio_dram_pkg::CMD_MODE |=> MODE_WORD == $past(LOCATION_ADDRESS[sio_dram_pkg::MODE_W-1:0]))
    else $error("mode word did not take the address bits");
  chk_deselect_quiet: assert property (
    CHIP_SELECT_N |=> $stable(MODE_WORD) && !REFRESH_STROBE && wq_wr_r == $past(wq_wr_r))
    else $error("command accepted while deselected");
  chk_read_latency: assert property (
    cmd == sio_dram_pkg::CMD_READ && delay_tap == 4'h3 |-> ##5 READ_VALID_FLAG)
    else $error("read data not valid at the configured delay");
  chk_burst_eight: assert property (
    tap_v && words_per_burst == 4'h8 |=> READ_VALID_FLAG [*8])
    else $error("eight word burst cut short");
  chk_burst_end: assert property (
    rd_state_r == sio_dram_pkg::RD_BURST && rd_cnt_r == words_per_burst && !tap_v |=> !READ_VALID_FLAG)
    else $error("burst ran past its length");
  chk_idle_keeps_burst: assert property (
    rd_state_r == sio_dram_pkg::RD_BURST && rd_cnt_r < words_per_burst
      && cmd == sio_dram_pkg::CMD_IDLE |=> READ_VALID_FLAG)
    else $error("idle command disturbed a read burst");
  chk_refresh_row: assert property (
    cmd == sio_dram_pkg::CMD_REF |=> REFRESH_STROBE && REFRESH_ROW == $past(ref_row_sel)
      && row_of[$past(BANK_SELECT)] == sio_dram_pkg::ROW_W'($past(ref_row_sel) + 1'b1))
    else $error("refresh row counter misbehaved");
  chk_write_queue: assert property (
    cmd == sio_dram_pkg::CMD_WRITE |=> wq_wr_r == sio_dram_pkg::QPTR_W'($past(wq_wr_r) + 1'b1))
    else $error("write command not queued");
  chk_write_masked: assert property (
    commit_now && beat0_mask |=> mem[$past(head_idx)] == $past(head_word))
    else $error("masked beat changed storage");
  chk_write_stored: assert property (
    commit_now && !beat0_mask |=> mem[$past(head_idx)] == $past(beat0_data))
    else $error("unmasked beat not stored");
  chk_lane_clocks: assert property (
    RSTN |=> READ_DATA_CLOCK[0] == READ_DATA_CLOCK[1] && READ_DATA_CLOCK[0] != $past(READ_DATA_CLOCK[0]))
    else $error("read data clocks out of step");

  cov_read_burst: cover property (tap_v && words_per_burst == 4'h8);
  cov_write_commit: cover property (commit_now);
  cov_refresh: cover property (cmd == sio_dram_pkg::CMD_REF ##1 cmd == sio_dram_pkg::CMD_REF);
  cov_mode_load: cover property (cmd == sio_dram_pkg::CMD_MODE);
endmodule
`default_nettype wire

// File: dv/sio_dram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sio_dram_ctrl_model (
  // write data link toward the device
  output var logic wdclk,
  output var logic [17:0] wdata,
  output var logic wmask
);
  // two pulses inside the reset window let the link side reset cleanly
  initial begin
    wdclk = 1'b0;
    wdata = 18'h00000;
    wmask = 1'b0;
    repeat (2) begin
      #15 wdclk = 1'b1;
      #15 wdclk = 1'b0;
    end
  end

  // one frame of two beats; the link clock stands low outside frames
  task automatic burst(input logic [17:0] d0, input logic [17:0] d1, input logic [1:0] m, input int lag);
    #(lag);
    wdata = d0;
    wmask = m[0];
    #7.5 wdclk = 1'b1;
    #7.5 wdata = d1;
    wmask = m[1];
    #7.5 wdclk = 1'b0;
    // released lines flip so a stale beat can never pass for fresh data
    #7.5 wdata = ~d1;
    wmask = ~m[1];
  endtask
endmodule
`default_nettype wire

// File: dv/ddr_sio_dram_command_interface_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_sio_dram_command_interface_bench;
  // command codes on {write enable, refresh enable}
  localparam logic [1:0] op_mode = 2'h0;
  localparam logic [1:0] op_write = 2'h1;
  localparam logic [1:0] op_refresh = 2'h2;
  localparam logic [1:0] op_read = 2'h3;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n = 1'b1;
  logic we_n = 1'b1;
  logic ref_n = 1'b1;
  logic [2:0] bank = 3'h0;
  logic [21:0] addr = 22'h000000;
  logic wdclk;
  logic [17:0] wdata;
  logic wmask;
  logic [17:0] rdata;
  logic rvalid;
  logic [1:0] rclk;
  logic [17:0] mode;
  logic rstrobe;
  logic [12:0] rrow;
  logic [17:0] mem [128];
  logic known [128] = '{default: 1'b0};
  logic [12:0] rows [$];
  int fails = 0;
  int tests_run = 0;

  sio_dram_cmd_if sio_dram_cmd_if_i (
    .SYS_CLK(sys_clk), .RSTN(rstn), .CHIP_SELECT_N(cs_n), .WRITE_ENABLE_N(we_n),
    .REFRESH_ENABLE_N(ref_n), .BANK_SELECT(bank), .LOCATION_ADDRESS(addr),
    .WRITE_DATA_CLOCK(wdclk), .WRITE_DATA(wdata), .WRITE_MASK(wmask),
    .READ_DATA(rdata), .READ_VALID_FLAG(rvalid), .READ_DATA_CLOCK(rclk),
    .MODE_WORD(mode), .REFRESH_STROBE(rstrobe), .REFRESH_ROW(rrow)
  );
  sio_dram_ctrl_model sio_dram_ctrl_model_i (.wdclk(wdclk), .wdata(wdata), .wmask(wmask));

  // steady, always-driven command clock
  always #10 sys_clk = ~sys_clk;

  // log every refresh pulse with the row it used
  always @(posedge sys_clk) begin
    if (rstrobe === 1'b1) begin
      rows.push_back(rrow);
    end
  end

  task automatic check_word(input string what, input logic [21:0] exp, input logic [21:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one command for one edge, then deselect with mode-load junk on the code pins
  task automatic cmd(input logic [1:0] code, input logic [2:0] b, input logic [21:0] a);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    {we_n, ref_n} <= code;
    bank <= b;
    addr <= a;
    @(posedge sys_clk);
    cs_n <= 1'b1;
    {we_n, ref_n} <= op_mode;
    addr <= ~a;
    #1;
  endtask

  // read a burst and follow it edge by edge
  task automatic read_burst(input logic [2:0] b, input logic [3:0] loc, input int rd_delay, input int words);
    logic [6:0] idx;
    logic last_clk;
    logic in_win;
    cmd(op_read, b, {18'h0, loc});
    last_clk = rclk[0];
    for (int k = 1; k <= rd_delay + words + 1; k++) begin
      @(posedge sys_clk);
      #1;
      idx = {b, 4'(loc + k - rd_delay)};
      in_win = (k >= rd_delay) && (k < rd_delay + words);
      check_bit("read valid", in_win, rvalid);
      if (in_win && known[idx]) begin
        check_word("read data", {4'h0, mem[idx]}, {4'h0, rdata});
      end
      check_bit("data clock toggle", ~last_clk, rclk[0]);
      check_bit("data clock pair", rclk[0], rclk[1]);
      last_clk = rclk[0];
    end
  endtask

  // write two beats and track what the array should now hold
  task automatic write_burst(input logic [2:0] b, input logic [3:0] loc, input logic [17:0] d0,
                             input logic [17:0] d1, input logic [1:0] m, input int lag);
    logic [6:0] idx;
    cmd(op_write, b, {18'h0, loc});
    sio_dram_ctrl_model_i.burst(d0, d1, m, lag);
    for (int k = 0; k < 2; k++) begin
      idx = {b, 4'(loc + k)};
      if (!m[k]) begin
        mem[idx] = k ? d1 : d0;
        known[idx] = 1'b1;
      end
    end
    // commit lands a few edges after the last beat
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic test_reset();
    @(posedge sys_clk);
    #1;
    check_word("mode after reset", 22'h0, {4'h0, mode});
    check_bit("valid idle", 1'b0, rvalid);
    check_bit("strobe idle", 1'b0, rstrobe);
    check_word("data clocks start", 22'h3, {20'h0, rclk});
    $display("test_reset done");
  endtask

  // second write masks its odd beat, which lands at the bank wrap point
  task automatic test_write_mask();
    write_burst(3'h5, 4'hf, 18'h2a5a5, 18'h15a5a, 2'b00, 0);
    write_burst(3'h5, 4'hf, 18'h3c0f0, 18'h0ff0f, 2'b10, 40);
    // third write masks its even beat over a known word
    write_burst(3'h5, 4'hf, 18'h12345, 18'h0abcd, 2'b01, 20);
    read_burst(3'h5, 4'hf, 4, 2);
    $display("test_write_mask done");
  endtask

  task automatic test_refresh();
    int n0;
    n0 = rows.size();
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      cs_n <= 1'b0;
      {we_n, ref_n} <= op_refresh;
      bank <= 3'(i);
      addr <= 22'h3fffff;
    end
    @(posedge sys_clk);
    cs_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check_word("refresh pulses", 22'h8, 22'(rows.size() - n0));
    cmd(op_refresh, 3'h0, 22'h000000);
    repeat (3) @(posedge sys_clk);
    check_word("single refresh pulse", 22'h9, 22'(rows.size() - n0));
    check_word("bank row advanced", {9'h0, rows[n0] + 13'h1}, {9'h0, rows[n0 + 8]});
    $display("test_refresh done");
  endtask

  // each entry: latency field, burst code, words; mode loads only between bursts
  task automatic test_mode_latency();
    int cfgs [4] = '{3, 0, 7, 0};
    int codes [4] = '{1, 2, 3, 0};
    int word_counts [4] = '{4, 8, 2, 2};
    logic [17:0] val;
    for (int i = 0; i < 4; i++) begin
      val = {1'b1, 12'h0, 2'(codes[i]), 3'(cfgs[i])};
      cmd(op_mode, 3'h7, {4'hf, val});
      check_word("mode word", {4'h0, val}, {4'h0, mode});
      read_burst(3'h5, 4'hf, 4 + cfgs[i], word_counts[i]);
      check_word("mode kept", {4'h0, val}, {4'h0, mode});
    end
    $display("test_mode_latency done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // the whole sequence needs well under ten microseconds
  initial begin
    #100000;
    fails++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    test_reset();
    test_write_mask();
    test_refresh();
    test_mode_latency();
    tally_and_finish();
  end
endmodule
`default_nettype wire
